/* hw/ssq_regs.svh */
`ifndef SSQ_REGS_SVH
`define SSQ_REGS_SVH
// ==========================================================
// register indexes (byte address is four times the index)
`define SSQ_IDX_SLOT22 8'h36
`define SSQ_IDX_SLOT23 8'h37
`define SSQ_IDX_SLOT24 8'h38
`define SSQ_IDX_STATUS 8'h3F
// ==========================================================
// reset values
`define SSQ_RST_SLOT22 16'h6C00
`define SSQ_RST_SLOT23 16'h6E00
`define SSQ_RST_SLOT24 16'h7000
// ==========================================================
// field positions of a slot word
`define SSQ_POS_DIR 15
`define SSQ_POS_ADDR 9
`define SSQ_POS_RET 8
`define SSQ_POS_CHB 4
`define SSQ_POS_CHA 0
// ==========================================================
// bus answers
`define SSQ_RESP_OKAY 2'h0
`define SSQ_RESP_SLVERR 2'h2
`endif

/* hw/ssq_pkg.sv */
package ssq_pkg;
  // one slot word, msb first
  typedef struct packed {
    logic dir;
    logic [5:0] addr;
    logic ret;
    logic [3:0] ch_b;
    logic [3:0] ch_a;
  } ssq_slot_t;

  typedef struct packed {
    logic [3:0] ch_b;
    logic [3:0] ch_a;
  } ssq_chan_pair_t;

  // gray along 22 -> 23 -> 24
  typedef enum logic [1:0] {
    SSQ_SLOT22 = 2'b00,
    SSQ_SLOT23 = 2'b01,
    SSQ_SLOT24 = 2'b11
  } ssq_active_t;

  typedef enum logic [2:0] {
    SSQ_SEL_S22 = 3'h0,
    SSQ_SEL_S23 = 3'h1,
    SSQ_SEL_S24 = 3'h2,
    SSQ_SEL_STAT = 3'h3,
    SSQ_SEL_NONE = 3'h4
  } ssq_sel_t;
endpackage

/* hw/ssq_slots.sv */
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ssq_regs.svh"
// Summary of operation
// - bit 15 set requests a write to the slot, clear requests a read
// - bits 14..9 hold the slot address; only matching writes land; resets to it
// - return flag clear: advance to next slot after conversion completes
// - return flag set: jump to first slot after conversion completes
// - bits 7..4 give converter B channel code of active slot, reset zero
// - bits 3..0 give converter A channel code of active slot, reset zero
// - slot 23 at 0x37 resets to 0x6E00
// - slot 24 at 0x38 resets to 0x7000
module ssq_slots (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // axi4-lite write address and data
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sequencer side
  input wire logic conv_done,
  output ssq_pkg::ssq_chan_pair_t chan_pair,
  output logic [1:0] active_slot,
  output logic return_pulse
);
  // ==========================================================
  // decode
  function automatic ssq_pkg::ssq_sel_t decode(input logic [9:0] a);
    ssq_pkg::ssq_sel_t s;
    s = ssq_pkg::SSQ_SEL_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[9:2])
        `SSQ_IDX_SLOT22: s = ssq_pkg::SSQ_SEL_S22;
        `SSQ_IDX_SLOT23: s = ssq_pkg::SSQ_SEL_S23;
        `SSQ_IDX_SLOT24: s = ssq_pkg::SSQ_SEL_S24;
        `SSQ_IDX_STATUS: s = ssq_pkg::SSQ_SEL_STAT;
        default: s = ssq_pkg::SSQ_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  function automatic logic [5:0] own_addr(input logic [1:0] i);
    logic [5:0] r;
    r = 6'h00;
    case (i)
      2'h0: r = 6'(`SSQ_IDX_SLOT22);
      2'h1: r = 6'(`SSQ_IDX_SLOT23);
      2'h2: r = 6'(`SSQ_IDX_SLOT24);
      default: r = 6'h00;
    endcase
    return r;
  endfunction

  // ==========================================================
  // state
  ssq_pkg::ssq_slot_t slot_r [3];
  ssq_pkg::ssq_slot_t slot_nxt [3];
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  ssq_pkg::ssq_sel_t aw_sel_r, aw_sel_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  ssq_pkg::ssq_active_t act_r, act_nxt;
  ssq_pkg::ssq_chan_pair_t chan_r, chan_nxt;
  logic ret_pulse_r, ret_pulse_nxt;
  logic [1:0] act_idx;
  logic do_write;
  ssq_pkg::ssq_slot_t wword;

  function automatic logic [1:0] idx_of(input ssq_pkg::ssq_active_t a);
    logic [1:0] r;
    r = 2'h0;
    case (a)
      ssq_pkg::SSQ_SLOT22: r = 2'h0;
      ssq_pkg::SSQ_SLOT23: r = 2'h1;
      ssq_pkg::SSQ_SLOT24: r = 2'h2;
      default: r = 2'h0;
    endcase
    return r;
  endfunction

  // ==========================================================
  // bus slave
  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready = !w_have_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign do_write = aw_have_r && w_have_r && !bvalid_r;
  assign wword = ssq_pkg::ssq_slot_t'(wdata_r[15:0]);

  always_comb begin
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    aw_sel_nxt = aw_sel_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    for (int i = 0; i < 3; i++) begin
      slot_nxt[i] = slot_r[i];
    end
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_nxt = 1'b1;
      aw_sel_nxt = decode(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (do_write) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (aw_sel_r == ssq_pkg::SSQ_SEL_NONE) ? `SSQ_RESP_SLVERR : `SSQ_RESP_OKAY;
      // a word with the read direction or a foreign address is not stored
      if (aw_sel_r != ssq_pkg::SSQ_SEL_NONE && aw_sel_r != ssq_pkg::SSQ_SEL_STAT && wword.dir &&
          wword.addr == own_addr(aw_sel_r[1:0]) && wstrb_r[1:0] == 2'h3) begin
        slot_nxt[aw_sel_r[1:0]] = wword;
      end
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `SSQ_RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      case (decode(s_axi_araddr))
        ssq_pkg::SSQ_SEL_S22: rdata_nxt[15:0] = slot_r[0];
        ssq_pkg::SSQ_SEL_S23: rdata_nxt[15:0] = slot_r[1];
        ssq_pkg::SSQ_SEL_S24: rdata_nxt[15:0] = slot_r[2];
        ssq_pkg::SSQ_SEL_STAT: rdata_nxt[1:0] = act_idx;
        default: rresp_nxt = `SSQ_RESP_SLVERR;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_sel_r <= ssq_pkg::SSQ_SEL_NONE;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `SSQ_RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= `SSQ_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      slot_r[0] <= `SSQ_RST_SLOT22;
      slot_r[1] <= `SSQ_RST_SLOT23;
      slot_r[2] <= `SSQ_RST_SLOT24;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      aw_sel_r <= aw_sel_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      slot_r <= slot_nxt;
    end
  end

  // ==========================================================
  // sequencer walk over the three slots
  assign act_idx = idx_of(act_r);
  assign chan_pair = chan_r;
  assign active_slot = act_idx;
  assign return_pulse = ret_pulse_r;

  always_comb begin
    act_nxt = act_r;
    ret_pulse_nxt = 1'b0;
    if (conv_done) begin
      if (slot_r[act_idx].ret) begin
        act_nxt = ssq_pkg::SSQ_SLOT22;
        ret_pulse_nxt = 1'b1;
      end else begin
        case (act_r)
          ssq_pkg::SSQ_SLOT22: act_nxt = ssq_pkg::SSQ_SLOT23;
          ssq_pkg::SSQ_SLOT23: act_nxt = ssq_pkg::SSQ_SLOT24;
          // past the last slot held here the walk wraps
          default: act_nxt = ssq_pkg::SSQ_SLOT22;
        endcase
      end
    end
    // codes pass through untouched; a write to the active slot shows next cycle
    chan_nxt.ch_b = slot_nxt[idx_of(act_nxt)].ch_b;
    chan_nxt.ch_a = slot_nxt[idx_of(act_nxt)].ch_a;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      act_r <= ssq_pkg::SSQ_SLOT22;
      chan_r <= 8'h00;
      ret_pulse_r <= 1'b0;
    end else begin
      act_r <= act_nxt;
      chan_r <= chan_nxt;
      ret_pulse_r <= ret_pulse_nxt;
    end
  end

  // ==========================================================
  // checks
  ret_jump_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    conv_done && slot_r[act_idx].ret |=> act_r == ssq_pkg::SSQ_SLOT22 && return_pulse)
    else $error("return flag did not send the walk to the first slot");
  adv_next_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    conv_done && !slot_r[act_idx].ret && act_r != ssq_pkg::SSQ_SLOT24 |=> act_idx == $past(act_idx) + 2'h1)
    else $error("walk did not advance to the next slot");
  hold_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !conv_done |=> $stable(act_r) && !return_pulse)
    else $error("active slot moved without a finished conversion");
  chan_b_out_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    chan_pair.ch_b == slot_r[act_idx].ch_b)
    else $error("converter b code differs from active slot");
  chan_a_out_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    chan_pair.ch_a == slot_r[act_idx].ch_a)
    else $error("converter a code differs from active slot");
  addr_fixed_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    slot_r[0].addr == 6'h36 && slot_r[1].addr == 6'h37 && slot_r[2].addr == 6'h38)
    else $error("slot address field changed");
  reset_vals_a: assert property (@(posedge clk_sys)
    !rstn |=> slot_r[1] == 16'h6E00 && slot_r[2] == 16'h7000 && chan_pair == 8'h00)
    else $error("slot reset value wrong");
  read_dir_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    do_write && !wword.dir |=> slot_r[0] == $past(slot_r[0]) && slot_r[1] == $past(slot_r[1]) &&
    slot_r[2] == $past(slot_r[2]))
    else $error("read request altered a slot");
  write_land_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    do_write && aw_sel_r == ssq_pkg::SSQ_SEL_S24 && wword.dir && wword.addr == 6'h38 && wstrb_r[1:0] == 2'h3
    |=> slot_r[2] == $past(wword) && s_axi_bvalid)
    else $error("valid write to slot 24 did not land");
  write_cov_c: cover property (@(posedge clk_sys) disable iff (!rstn) do_write && wword.dir);
  ret_cov_c: cover property (@(posedge clk_sys) disable iff (!rstn) return_pulse);
  wrap_cov_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    conv_done && act_r == ssq_pkg::SSQ_SLOT24 && !slot_r[2].ret);
endmodule

/* sim/ssq_conv_model.sv */
`timescale 1ns/1ps
// ==========================================================
// converter stand-in: one done pulse gap+1 cycles after kick,
// so the bench can play a prompt or a slow conversion
module ssq_conv_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // bench control
  input wire logic kick,
  input wire logic [3:0] gap,
  // sequencer side
  output logic conv_done,
  output logic busy
);
  logic [3:0] cnt_r;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_r <= 4'h0;
      busy <= 1'h0;
      conv_done <= 1'h0;
    end else begin
      conv_done <= busy && (cnt_r == 4'h0);
      if (kick) begin
        busy <= 1'h1;
        cnt_r <= gap;
      end else if (busy) begin
        if (cnt_r == 4'h0) begin
          busy <= 1'h0;
        end else begin
          cnt_r <= cnt_r - 4'h1;
        end
      end
    end
  end
endmodule

/* sim/sequencer_stack_slots_tb.sv */
`timescale 1ns/1ps
module sequencer_stack_slots_tb;
  // ==========================================================
  // signals
  logic clk_sys = 1'h0;
  logic rstn = 1'h0;
  logic [9:0] s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, kick = 1'h0, cd_d = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic conv_done, return_pulse;
  logic [3:0] gap = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, active_slot;
  logic [31:0] s_axi_rdata, seed;
  ssq_pkg::ssq_chan_pair_t chan_pair;
  logic [33:0] rq[$], bq[$], sq[$];
  logic [15:0] slot[3];
  int act, n_mismatch, compares;

  // write strobes stay full: writes lacking either strobe of bits 15..0 are dropped by design choice
  ssq_slots i_ssq_slots (.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .conv_done, .chan_pair, .active_slot, .return_pulse);
  ssq_conv_model i_ssq_conv_model (.clk_sys, .rstn, .kick, .gap, .conv_done, .busy());

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [33:0] e, input logic [33:0] g);
    compares++;
    if (e !== g) begin
      n_mismatch++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // one compare per kind of result: read word, write answer, sequencer step
  task automatic cmp_read(input logic [33:0] e, input logic [33:0] g);
    check(e, g);
  endtask

  task automatic cmp_resp(input logic [33:0] e, input logic [33:0] g);
    check(e, g);
  endtask

  task automatic cmp_seq(input logic [33:0] e, input logic [33:0] g);
    check(e, g);
  endtask

  task automatic finish_test();
    $display("counts: compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // bus master; the model only takes writes that carry write direction and own address
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    int k;
    k = idx - 8'h36;
    if (k >= 0 && k < 3 && d[15] && d[14:9] == idx[5:0]) slot[k] = d[15:0];
    bq.push_back({(k >= 0 && k < 3) || idx == 8'h3F ? 2'h0 : 2'h2, 32'h0});
    @(posedge clk_sys);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] idx);
    int k;
    k = idx - 8'h36;
    rq.push_back((k >= 0 && k < 3) ? {2'h0, 16'h0, slot[k]} :
      (idx == 8'h3F) ? {2'h0, 30'h0, act[1:0]} : {2'h2, 32'h0});
    @(posedge clk_sys);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask

  task automatic conv(input logic [3:0] g);
    logic r;
    r = slot[act][8];
    act = r ? 0 : (act + 1) % 3;
    sq.push_back({23'h0, r, act[1:0], slot[act][7:0]});
    @(posedge clk_sys);
    kick <= 1'h1;
    gap <= g;
    @(posedge clk_sys);
    kick <= 1'h0;
    do @(posedge clk_sys); while (!conv_done);
  endtask

  // ==========================================================
  // result watcher
  always @(posedge clk_sys) begin
    if (s_axi_rvalid && s_axi_rready) cmp_read(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) cmp_resp(bq.pop_front(), {s_axi_bresp, 32'h0});
    if (cd_d) cmp_seq(sq.pop_front(), {23'h0, return_pulse, active_slot, chan_pair});
    cd_d <= conv_done;
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    finish_test();
  end

  initial begin
    seed = 32'h4703A218;
    slot[0] = 16'h6C00;
    slot[1] = 16'h6E00;
    slot[2] = 16'h7000;
    act = 0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'h1;
    for (logic [7:0] j = 8'h36; j < 8'h39; j++) rd(j);
    rd(8'h40);
    $display("test reset values done");
    repeat (2) begin
      for (logic [7:0] j = 8'h36; j < 8'h39; j++) begin
        seed = xs(seed);
        wr(j, {16'h0, 1'h1, j[5:0], 1'h0, seed[7:0]});
        rd(j);
      end
    end
    $display("test write read done");
    seed = xs(seed);
    wr(8'h36, {16'h0, 1'h0, 6'h36, 1'h0, seed[7:0]});
    wr(8'h37, {16'h0, 1'h1, 6'h38, 1'h0, seed[15:8]});
    wr(8'h40, 32'h0000FFFF);
    wr(8'h3F, 32'h0000FFFF);
    rd(8'h36);
    rd(8'h37);
    $display("test refused writes done");
    for (int i = 0; i < 4; i++) conv(i[3:0]);
    rd(8'h3F);
    seed = xs(seed);
    wr(8'h37, {16'h0, 1'h1, 6'h37, 1'h1, seed[7:0]});
    repeat (3) conv(4'h0);
    $display("test sequencer done");
    // let the watcher take the last notes before the verdict
    repeat (2) @(posedge clk_sys);
    check(34'h0, 34'(rq.size() + bq.size() + sq.size()));
    finish_test();
  end
endmodule
